// [design/rtc_protect_trickle_burst.sv]
// Serial register engine with write guard, trickle charger decode and burst sequencing.
// Operation
// - Guard flag is control bit 7, rest zero.
// - Guard set blocks writes to other registers.
// - Charger enabled only by key pattern 1010.
// - Charger path starts disabled after power-up.
// - Diode field 01/10 valid, else disabled.
// - Resistor field 00 disables, others pick resistor.
// - Clock burst moves eight registers from zero.
// - Guard at burst start blocks all eight.
// - Charger register never reached by clock burst.
// - Clock burst read shifts from snapshot copy.
// - Thirty-one bytes of scratch RAM provided.
// - RAM burst moves 31 bytes from zero.
// - Command byte layout: enable, space, address, direction.
// - Address all ones requests a burst.
// - Clock burst commits only after eighth byte.
// - RAM burst stores each completed byte.
`timescale 1ns/1ps
`include "rtc_defs.svh"

module rtc_protect_trickle_burst (
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic       SCLK,
    input  wire logic       CE,
    input  wire logic       IO_IN,
    output logic            IO_OUT,
    output logic            IO_OE,
    output logic            CHG_EN,
    output logic [1:0]      CHG_DIODES,
    output logic [1:0]      CHG_RES
);
    import rtc_pkg::*;

    logic                   hold_q;
    logic                   link_rst_n;
    logic                   frame_rst_n;
    phase_t                 phase_q;
    logic [2:0]             bit_q;
    cmd_t                   cmd_q;
    cmd_t                   cmd_next;
    logic [7:0]             rx_q;
    logic [7:0]             rx_byte;
    logic [4:0]             idx_q;
    logic                   guard_start_q;
    logic                   io_q;
    logic                   wp_q;
    charger_t               charger_q;
    logic [7:0]             time_q [0:`RTC_TIME_REGS-1];
    logic [7:0]             stage_q [0:`RTC_TIME_REGS-1];
    logic [7:0]             shadow_q [0:`RTC_CLK_REGS-1];
    logic [7:0]             ram_q [0:`RTC_RAM_BYTES-1];
    logic [7:0]             ctrl_byte;
    logic [7:0]             rd_byte;
    logic [4:0]             sel;
    logic                   cmd_last;
    logic                   byte_last;
    logic                   burst;
    logic                   reading;
    logic                   wr_byte;
    logic                   single_wr;
    logic                   clk_burst_wr;
    logic                   ram_burst_wr;
    logic                   commit;
    logic                   snap;
    charger_t               chg_s1_q;
    charger_t               chg_s2_q;
    charger_t               chg_s3_q;
    logic                   chg_valid;

    // The link logic is released while SCLK idles low before any frame, so an
    // unsynchronised release is safe; a frame open during reset is lost.
    always_ff @(posedge CLK) begin
        hold_q <= RST_N;
    end

    assign link_rst_n  = hold_q;
    assign frame_rst_n = hold_q & CE;

    assign cmd_next  = cmd_t'({IO_IN, cmd_q[7:1]});
    assign rx_byte   = {IO_IN, rx_q[7:1]};
    assign cmd_last  = (phase_q == PH_CMD) && (bit_q == `RTC_LAST_BIT);
    assign byte_last = (phase_q == PH_DATA) && (bit_q == `RTC_LAST_BIT);
    assign burst     = (cmd_q.addr == `RTC_BURST_ADDR);
    assign reading   = (phase_q == PH_DATA) && cmd_q.rd;
    assign ctrl_byte = {wp_q, 7'h00};

    // Writes need the enable bit of the command and a write direction.
    assign wr_byte      = byte_last && !cmd_q.rd && cmd_q.write_en;
    assign single_wr    = wr_byte && !burst;
    assign clk_burst_wr = wr_byte && burst && (cmd_q.space_select_bit == `RTC_SPACE_CLOCK);
    assign ram_burst_wr = wr_byte && burst && (cmd_q.space_select_bit == `RTC_SPACE_RAM) && !wp_q;
    assign commit       = clk_burst_wr && (idx_q == `RTC_CLK_LAST) && !guard_start_q;
    assign snap         = cmd_last && cmd_next.rd && (cmd_next.addr == `RTC_BURST_ADDR)
                          && (cmd_next.space_select_bit == `RTC_SPACE_CLOCK);

    // Frame sequencing; dropping CE ends any transfer at once.
    always_ff @(posedge SCLK or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            phase_q       <= PH_CMD;
            bit_q         <= `RTC_FIRST_BIT;
            cmd_q         <= cmd_t'(`RTC_BYTE_ZERO);
            rx_q          <= `RTC_BYTE_ZERO;
            idx_q         <= `RTC_IDX_ZERO;
            guard_start_q <= `RTC_GUARD_RESET;
        end else begin
            bit_q <= bit_q + 3'h1;
            unique case (phase_q)
                PH_CMD: begin
                    cmd_q <= cmd_next;
                    if (cmd_last) begin
                        phase_q       <= PH_DATA;
                        idx_q         <= `RTC_IDX_ZERO;
                        guard_start_q <= wp_q;
                    end
                end
                PH_DATA: begin
                    rx_q <= rx_byte;
                    if (byte_last && burst) begin
                        if (cmd_q.space_select_bit == `RTC_SPACE_CLOCK) begin
                            idx_q <= (idx_q == `RTC_CLK_LAST) ? `RTC_IDX_ZERO : idx_q + `RTC_IDX_ONE;
                            if (!cmd_q.rd && idx_q == `RTC_CLK_LAST) begin
                                phase_q <= PH_DONE;
                            end
                        end else begin
                            idx_q <= (idx_q == `RTC_RAM_LAST) ? `RTC_IDX_ZERO : idx_q + `RTC_IDX_ONE;
                            if (!cmd_q.rd && idx_q == `RTC_RAM_LAST) begin
                                phase_q <= PH_DONE;
                            end
                        end
                    end else if (byte_last && !cmd_q.rd) begin
                        phase_q <= PH_DONE;
                    end
                end
                PH_DONE: begin
                    phase_q <= PH_DONE;
                end
            endcase
        end
    end

    // Write guard and charger configuration.
    always_ff @(posedge SCLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            wp_q      <= `RTC_GUARD_RESET;
            charger_q <= charger_t'(`RTC_CHG_RESET);
        end else if (commit) begin
            wp_q <= rx_byte[`RTC_GUARD_BIT];
        end else if (single_wr && cmd_q.space_select_bit == `RTC_SPACE_CLOCK) begin
            if (cmd_q.addr == `RTC_CTRL_ADDR) begin
                wp_q <= rx_byte[`RTC_GUARD_BIT];
            end else if (cmd_q.addr == `RTC_CHG_ADDR && !wp_q) begin
                charger_q <= charger_t'(rx_byte);
            end
        end
    end

    // Time registers; nothing advances them, only single writes and clock burst commits load them.
    always_ff @(posedge SCLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            for (int i = 0; i < `RTC_TIME_REGS; i++) begin
                time_q[i] <= `RTC_BYTE_ZERO;
            end
        end else if (commit) begin
            for (int i = 0; i < `RTC_TIME_REGS; i++) begin
                time_q[i] <= stage_q[i];
            end
        end else if (single_wr && cmd_q.space_select_bit == `RTC_SPACE_CLOCK
                     && cmd_q.addr < `RTC_CTRL_ADDR && !wp_q) begin
            time_q[cmd_q.addr[2:0]] <= rx_byte;
        end
    end

    // Burst bytes wait here so that a partial clock burst changes nothing.
    always_ff @(posedge SCLK) begin
        if (clk_burst_wr && idx_q < `RTC_CLK_LAST) begin
            stage_q[idx_q[2:0]] <= rx_byte;
        end
    end

    always_ff @(posedge SCLK) begin
        if (snap) begin
            for (int i = 0; i < `RTC_TIME_REGS; i++) begin
                shadow_q[i] <= time_q[i];
            end
            shadow_q[`RTC_CLK_REGS-1] <= ctrl_byte;
        end
    end

    always_ff @(posedge SCLK) begin
        if (ram_burst_wr) begin
            ram_q[idx_q] <= rx_byte;
        end else if (single_wr && cmd_q.space_select_bit == `RTC_SPACE_RAM && !wp_q) begin
            ram_q[cmd_q.addr] <= rx_byte;
        end
    end

    assign sel = burst ? idx_q : cmd_q.addr;

    always_comb begin
        rd_byte = `RTC_BYTE_ZERO;
        if (cmd_q.space_select_bit == `RTC_SPACE_RAM) begin
            if (sel <= `RTC_RAM_LAST) begin
                rd_byte = ram_q[sel];
            end
        end else if (burst) begin
            rd_byte = shadow_q[sel[2:0]];
        end else if (sel < `RTC_CTRL_ADDR) begin
            rd_byte = time_q[sel[2:0]];
        end else if (sel == `RTC_CTRL_ADDR) begin
            rd_byte = ctrl_byte;
        end else if (sel == `RTC_CHG_ADDR) begin
            rd_byte = charger_q;
        end
    end

    // Read bits leave on the falling edge, least significant bit first.
    always_ff @(negedge SCLK or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            io_q <= 1'b0;
        end else if (reading) begin
            io_q <= rd_byte[bit_q];
        end
    end

    // The pin lets go while SCLK is high, so the line is free on every rising edge.
    assign IO_OUT = io_q;
    assign IO_OE  = reading && !SCLK && CE;

    // The configuration is static while it crosses; outputs follow only once two
    // samples agree, which hides bits caught in mid change.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            chg_s1_q <= charger_t'(`RTC_CHG_RESET);
            chg_s2_q <= charger_t'(`RTC_CHG_RESET);
            chg_s3_q <= charger_t'(`RTC_CHG_RESET);
        end else begin
            chg_s1_q <= charger_q;
            chg_s2_q <= chg_s1_q;
            chg_s3_q <= chg_s2_q;
        end
    end

    assign chg_valid = (chg_s2_q.charge_key_field == `RTC_CHG_KEY)
                       && (chg_s2_q.diode_count_field == `RTC_DIODE_ONE
                           || chg_s2_q.diode_count_field == `RTC_DIODE_TWO)
                       && (chg_s2_q.resistor_pick_field != `RTC_RES_NONE);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            CHG_EN     <= 1'b0;
            CHG_DIODES <= 2'h0;
            CHG_RES    <= 2'h0;
        end else if (chg_s2_q == chg_s3_q) begin
            CHG_EN     <= chg_valid;
            CHG_DIODES <= chg_valid ? chg_s2_q.diode_count_field : 2'h0;
            CHG_RES    <= chg_valid ? chg_s2_q.resistor_pick_field : 2'h0;
        end
    end

    sequence seq_byte_in;
        byte_last;
    endsequence

    sequence seq_clk_burst_end;
        clk_burst_wr && (idx_q == `RTC_CLK_LAST);
    endsequence

    chk_guard_low_zero: assert property (@(posedge SCLK) disable iff (!link_rst_n)
        (reading && !burst && cmd_q.space_select_bit == `RTC_SPACE_CLOCK && cmd_q.addr == `RTC_CTRL_ADDR)
        |-> (rd_byte[6:0] == 7'h00 && rd_byte[`RTC_GUARD_BIT] == wp_q)) else $error("control low bits not zero");

    chk_guard_blocks_chg: assert property (@(posedge SCLK) disable iff (!link_rst_n)
        (seq_byte_in ##0 (wp_q && !burst && cmd_q.addr == `RTC_CHG_ADDR)) |=> $stable(charger_q))
        else $error("charger written while guarded");

    chk_key_gates_en: assert property (@(posedge CLK) disable iff (!RST_N)
        CHG_EN |-> $past(chg_s3_q.charge_key_field) == `RTC_CHG_KEY) else $error("charger on without key");

    chk_reset_charger_off: assert property (@(posedge CLK)
        !$past(RST_N) |-> !CHG_EN ##1 !CHG_EN) else $error("charger on after reset");

    chk_diode_decode: assert property (@(posedge CLK) disable iff (!RST_N)
        CHG_EN |-> (CHG_DIODES == `RTC_DIODE_ONE || CHG_DIODES == `RTC_DIODE_TWO))
        else $error("bad diode select while enabled");

    chk_res_decode: assert property (@(posedge CLK) disable iff (!RST_N)
        CHG_EN |-> (CHG_RES != `RTC_RES_NONE && CHG_RES == $past(chg_s3_q.resistor_pick_field)))
        else $error("bad resistor select while enabled");

    chk_burst_wraps: assert property (@(posedge SCLK) disable iff (!frame_rst_n)
        (seq_byte_in ##0 (burst && cmd_q.rd && cmd_q.space_select_bit == `RTC_SPACE_CLOCK
        && idx_q == `RTC_CLK_LAST)) |=> idx_q == `RTC_IDX_ZERO) else $error("clock burst did not wrap");

    chk_burst_commit: assert property (@(posedge SCLK) disable iff (!link_rst_n)
        seq_clk_burst_end |=> (time_q[0] == ($past(guard_start_q) ? $past(time_q[0]) : $past(stage_q[0]))
        && wp_q == ($past(guard_start_q) ? $past(wp_q) : $past(rx_byte[`RTC_GUARD_BIT]))))
        else $error("clock burst commit out of place");

    chk_burst_no_chg: assert property (@(posedge SCLK) disable iff (!link_rst_n)
        clk_burst_wr |=> $stable(charger_q)) else $error("burst touched charger");

    chk_snapshot_copy: assert property (@(posedge SCLK) disable iff (!link_rst_n)
        snap |=> shadow_q[0] == $past(time_q[0]) && shadow_q[`RTC_CLK_REGS-1] == $past(ctrl_byte))
        else $error("snapshot not taken");

    chk_ram_store: assert property (@(posedge SCLK) disable iff (!link_rst_n)
        ram_burst_wr |=> ram_q[$past(idx_q)] == $past(rx_byte)) else $error("RAM burst byte lost");

    chk_cmd_write_gate: assert property (@(posedge SCLK) disable iff (!link_rst_n)
        (byte_last && !cmd_q.write_en) |=> ($stable(wp_q) && $stable(charger_q)))
        else $error("write without enable bit");

endmodule

// [inc/rtc_defs.svh]
// Numeric constants of the protected timekeeper control block.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define RTC_CLK_REGS       8
`define RTC_TIME_REGS      7
`define RTC_CTRL_ADDR      5'h07
`define RTC_CHG_ADDR       5'h08
`define RTC_BURST_ADDR     5'h1F
`define RTC_RAM_BYTES      31
`define RTC_RAM_LAST       5'h1E
`define RTC_CLK_LAST       5'h07
`define RTC_GUARD_BIT      7
`define RTC_LAST_BIT       3'h7
`define RTC_FIRST_BIT      3'h0
`define RTC_IDX_ZERO       5'h00
`define RTC_IDX_ONE        5'h01
`define RTC_CHG_KEY        4'hA
`define RTC_DIODE_ONE      2'h1
`define RTC_DIODE_TWO      2'h2
`define RTC_RES_NONE       2'h0
`define RTC_BYTE_ZERO      8'h00
`define RTC_GUARD_RESET    1'b1
`define RTC_CHG_RESET      8'h00
`define RTC_SPACE_CLOCK    1'b0
`define RTC_SPACE_RAM      1'b1

`endif

// [inc/rtc_pkg.sv]
// Types shared by the protected timekeeper control block.
package rtc_pkg;

    typedef struct packed {
        logic       write_en;
        logic       space_select_bit;
        logic [4:0] addr;
        logic       rd;
    } cmd_t;

    typedef struct packed {
        logic [3:0] charge_key_field;
        logic [1:0] diode_count_field;
        logic [1:0] resistor_pick_field;
    } charger_t;

    typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_DONE} phase_t;

endpackage

// [verif/rtc_host_model.sv]
// Host model of the three-wire link that frames commands and data bytes.
`timescale 1ns/1ps
module rtc_host_model (
    output logic      sclk,
    output logic      ce,
    output logic      drv,
    output logic      bit_o,
    input  wire logic io_wire
);
    logic [7:0] buf_q [0:31];
    initial begin
        sclk = 1'b0;
        ce = 1'b0;
        drv = 1'b0;
        bit_o = 1'b0;
    end
    // Data is set early in the low phase and the answer is sampled just before the rise.
    task automatic cycle(input logic oe, input logic b, output logic got);
        drv = oe;
        bit_o = b;
        #15;
        got = io_wire;
        #1 sclk = 1'b1;
        #16 sclk = 1'b0;
    endtask
    // The enable stays high and the clock runs until every byte has moved.
    task automatic frame(input logic [7:0] cmd, input int n);
        logic g;
        ce = 1'b1;
        for (int i = 0; i < 8; i++) cycle(1'b1, cmd[i], g);
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 8; i++) begin
                cycle(~cmd[0], buf_q[k][i], g);
                if (cmd[0]) buf_q[k][i] = g;
            end
        end
        drv = 1'b0;
        #16 ce = 1'b0;
        #200;
    endtask
endmodule

// [verif/tb_rtc_protect_trickle_burst.sv]
// Self-checking bench for the protected timekeeper control block.
`timescale 1ns/1ps
module tb_rtc_protect_trickle_burst;
    logic       clk;
    logic       rst_n;
    logic       sclk;
    logic       ce;
    logic       drv;
    logic       bit_o;
    logic       io_wire;
    logic       io_out;
    logic       io_oe;
    logic       chg_en;
    logic [1:0] chg_diodes;
    logic [1:0] chg_res;
    logic [7:0] want_q [0:31];
    int         n_mismatch;
    int         checks;
    int         cycles;
    // Charger settings beside the enable, diode and resistor outputs they should give.
    logic [7:0] row_cfg [0:10] = '{8'hA5, 8'hA6, 8'hAB, 8'hAD, 8'hA4, 8'hA0, 8'h55, 8'hB5, 8'hAE, 8'hA3, 8'hA9};
    logic [4:0] row_out [0:10] = '{5'h15, 5'h16, 5'h1B, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h19};

    // The data line has a pull-down, so it sits low when nobody drives it.
    assign io_wire = io_oe ? io_out : (drv ? bit_o : 1'b0);

    rtc_host_model host_u (.sclk(sclk), .ce(ce), .drv(drv), .bit_o(bit_o), .io_wire(io_wire));
    rtc_protect_trickle_burst dut_u (.CLK(clk), .RST_N(rst_n), .SCLK(sclk), .CE(ce), .IO_IN(io_wire),
        .IO_OUT(io_out), .IO_OE(io_oe), .CHG_EN(chg_en), .CHG_DIODES(chg_diodes), .CHG_RES(chg_res));

    always #5 clk = ~clk;

    task automatic test_done();
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Sampled away from the clock edge so the registered outputs have settled.
    task automatic check_chg(input logic [4:0] exp);
        @(negedge clk);
        check_byte("charger outputs", {3'h0, exp}, {3'h0, chg_en, chg_diodes, chg_res});
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic wr1(input logic [7:0] cmd, input logic [7:0] d);
        host_u.buf_q[0] = d;
        host_u.frame(cmd, 1);
    endtask
    task automatic rd1(input logic [7:0] cmd, input logic [7:0] exp, input string what);
        host_u.frame(cmd, 1);
        check_byte(what, exp, host_u.buf_q[0]);
    endtask
    task automatic burst_check(input logic [7:0] cmd, input int n);
        host_u.frame(cmd, n);
        for (int k = 0; k < n; k++) check_byte("burst byte", want_q[k], host_u.buf_q[k]);
    endtask
    task automatic fill(input logic [7:0] v);
        for (int k = 0; k < 32; k++) host_u.buf_q[k] = v;
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        n_mismatch = 0;
        checks = 0;
        cycles = 0;
        do_reset();
        wr1(8'h8E, 8'h00);
        for (int r = 0; r < 11; r++) begin
            wr1(8'h90, row_cfg[r]);
            check_chg(row_out[r]);
            rd1(8'h91, row_cfg[r], "charger register");
        end
        // A second reset in mid-run must drop the charger path that the last row enabled.
        do_reset();
        check_chg(5'h00);
        rd1(8'h8F, 8'h80, "guard after reset");
        wr1(8'h90, 8'hA5);
        check_chg(5'h00);
        rd1(8'h91, 8'h00, "guarded charger");
        wr1(8'h8E, 8'hFF);
        rd1(8'h8F, 8'h80, "control low bits");
        wr1(8'h8E, 8'h00);
        rd1(8'h8F, 8'h00, "guard cleared");
        wr1(8'h10, 8'hA5);
        rd1(8'h91, 8'h00, "write without enable bit");
        wr1(8'h90, 8'hA5);
        // The ninth byte read wraps back to register zero, which holds zero here.
        for (int i = 0; i < 9; i++) begin
            want_q[i] = (i < 7) ? 8'(i) * 8'h11 : 8'h00;
            host_u.buf_q[i] = want_q[i];
        end
        host_u.frame(8'hBE, 9);
        burst_check(8'hBF, 9);
        check_chg(5'h15);
        fill(8'hEE);
        host_u.frame(8'hBE, 5);
        burst_check(8'hBF, 8);
        wr1(8'h8E, 8'h80);
        want_q[7] = 8'h80;
        fill(8'h5A);
        host_u.frame(8'hBE, 8);
        burst_check(8'hBF, 8);
        wr1(8'h8E, 8'h00);
        for (int i = 0; i < 31; i++) begin
            want_q[i] = 8'h40 + 8'(i);
            host_u.buf_q[i] = want_q[i];
        end
        host_u.frame(8'hFE, 31);
        burst_check(8'hFF, 31);
        fill(8'hC7);
        host_u.frame(8'hFE, 2);
        rd1(8'hC3, 8'hC7, "ram byte 1");
        rd1(8'hC5, 8'h42, "ram byte 2");
        wr1(8'hFC, 8'h9D);
        rd1(8'hFD, 8'h9D, "ram byte 30");
        test_done();
    end
endmodule
